/* btox_regs.vh */
// Encodings, field positions, phase codes and PC/bank constants for the toggle/branch executor
`ifndef BTOX_REGS_VH
`define BTOX_REGS_VH
`define BTOX_OP_BIT_INVERT 4'h7
`define BTOX_OP_BRANCH_OVF 8'hE4
`define BTOX_OPC_HI 15
`define BTOX_OPC_LO 12
`define BTOX_BRA_HI 15
`define BTOX_BRA_LO 8
`define BTOX_BIT_HI 11
`define BTOX_BIT_LO 9
`define BTOX_BANK_SEL 8
`define BTOX_ADDR_HI 7
`define BTOX_ADDR_LO 0
`define BTOX_PC_STEP 21'h000002
`define BTOX_PC_RESET 21'h000000
`define BTOX_ACCESS_BANK 4'h0
`define BTOX_Q1 2'h0
`define BTOX_Q2 2'h1
`define BTOX_Q3 2'h2
`define BTOX_Q4 2'h3
`endif

/* btox_qphase.v */
// Quarter-phase sequencer: one Q1..Q4 rotation per instruction cycle
`include "btox_regs.vh"
module btox_qphase (
	input wire sys_clk_i,
	input wire rst_i,
	output reg [1:0] q_o,
	output wire q4_o
);
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q_o <= `BTOX_Q1;
		end else begin
			q_o <= q_o + 2'h1;
		end
	end
	assign q4_o = (q_o == `BTOX_Q4);
endmodule

/* btox_exec.v */
// Executor for bit invert, branch on overflow and two-word skip idling
`include "btox_regs.vh"
// What this block does
// - Opcode 0111 inverts bit b of f
// - Bank bit 0 uses access bank
// - Branch decoded from upper byte E4, signed offset
// - Branch only when overflow flag set
// - Target is PC plus 2 plus 2n
// - Branch 1 cycle, taken 2 cycles
module btox_exec #(
	parameter PC_W = 21
) (
	input wire sys_clk_i,
	input wire rst_i,
	input wire [15:0] instr_i,
	input wire instr_valid_i,
	input wire skip_taken_i,
	input wire skip_two_word_i,
	input wire ovf_flag_i,
	input wire [3:0] bank_pointer_reg_i,
	input wire [7:0] dmem_rdata_i,
	output reg [PC_W-1:0] pc_o,
	output reg [11:0] dmem_addr_o,
	output reg dmem_rd_o,
	output reg [7:0] dmem_wdata_o,
	output reg dmem_we_o,
	output wire [1:0] qphase_o,
	output wire busy_o,
	output wire flags_we_o
);
	localparam ST_EXEC = 2'h0;
	localparam ST_IDLE2 = 2'h1;
	localparam ST_IDLE1 = 2'h2;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [15:0] ir_reg;
	reg [7:0] mod_reg;
	wire [1:0] q;
	wire q4;
	wire is_invert;
	wire is_bra;
	wire [PC_W-1:0] offset2;
	wire [PC_W-1:0] pc_plus;
	btox_qphase u_qphase (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.q_o(q),
		.q4_o(q4)
	);
	assign qphase_o = q;
	assign is_invert = (state_reg == ST_EXEC) &&
		(ir_reg[`BTOX_OPC_HI:`BTOX_OPC_LO] == `BTOX_OP_BIT_INVERT);
	assign is_bra = (state_reg == ST_EXEC) &&
		(ir_reg[`BTOX_BRA_HI:`BTOX_BRA_LO] == `BTOX_OP_BRANCH_OVF);
	assign offset2 = {{(PC_W-9){ir_reg[7]}}, ir_reg[7:0], 1'b0};
	assign pc_plus = pc_o + `BTOX_PC_STEP;
	assign busy_o = (state_reg != ST_EXEC);
	assign flags_we_o = 1'b0;
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_EXEC: begin
				if (q4) begin
					if (instr_valid_i && skip_taken_i && skip_two_word_i) begin
						state_next = ST_IDLE2;
					end else if (is_bra && ovf_flag_i) begin
						state_next = ST_IDLE1;
					end
				end
			end
			ST_IDLE2: begin
				if (q4) begin
					state_next = ST_IDLE1;
				end
			end
			ST_IDLE1: begin
				if (q4) begin
					state_next = ST_EXEC;
				end
			end
			default: begin
				state_next = ST_EXEC;
			end
		endcase
	end
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_EXEC;
			ir_reg <= 16'h0000;
			mod_reg <= 8'h00;
			pc_o <= `BTOX_PC_RESET;
			dmem_addr_o <= 12'h000;
			dmem_rd_o <= 1'b0;
			dmem_wdata_o <= 8'h00;
			dmem_we_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			dmem_rd_o <= 1'b0;
			dmem_we_o <= 1'b0;
			case (q)
				`BTOX_Q1: begin
					// Decode: latch the fetched word, idle cycles fetch nothing
					if (state_reg == ST_EXEC && instr_valid_i) begin
						ir_reg <= instr_i;
					end else begin
						ir_reg <= 16'h0000;
					end
				end
				`BTOX_Q2: begin
					if (is_invert) begin
						if (ir_reg[`BTOX_BANK_SEL]) begin
							dmem_addr_o <= {bank_pointer_reg_i, ir_reg[`BTOX_ADDR_HI:`BTOX_ADDR_LO]};
						end else begin
							dmem_addr_o <= {`BTOX_ACCESS_BANK, ir_reg[`BTOX_ADDR_HI:`BTOX_ADDR_LO]};
						end
						dmem_rd_o <= 1'b1;
					end
				end
				`BTOX_Q3: begin
					if (is_invert) begin
						mod_reg <= dmem_rdata_i ^
							(8'h01 << ir_reg[`BTOX_BIT_HI:`BTOX_BIT_LO]);
					end
				end
				`BTOX_Q4: begin
					if (is_invert) begin
						dmem_wdata_o <= mod_reg;
						dmem_we_o <= 1'b1;
					end
					if (is_bra && ovf_flag_i) begin
						pc_o <= pc_plus + offset2;
					end else if (state_reg == ST_EXEC && instr_valid_i) begin
						pc_o <= pc_plus;
					end
				end
				default: begin
					ir_reg <= ir_reg;
				end
			endcase
		end
	end
endmodule

/* btox_exec_monitor.sv */
// Checker on the executor ports
module btox_exec_monitor (input wire sys_clk_i, rst_i, dmem_rd_o, dmem_we_o, busy_o,
	input wire flags_we_o, input wire [1:0] qphase_o, input wire [20:0] pc_o);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_idle;
		busy_o [*4];
	endsequence
	a_no_flag: assert property (!flags_we_o) else $error("flag");
	a_rd_we: assert property (dmem_rd_o |-> ##[2:3] dmem_we_o) else $error("write");
	a_we_q1: assert property (dmem_we_o |-> qphase_o == 2'h0) else $error("phase");
	a_pc_hold: assert property (qphase_o != 2'h3 |=> $stable(pc_o)) else $error("pc");
	a_idle_len: assert property ($rose(busy_o) |-> s_idle) else $error("idle");
	a_idle_in: assert property ($rose(busy_o) |-> qphase_o == 2'h0) else $error("in");
	a_idle_out: assert property ($fell(busy_o) |-> qphase_o == 2'h0) else $error("out");
	a_idle_rd: assert property (busy_o |-> !dmem_rd_o) else $error("read");
endmodule
bind btox_exec btox_exec_monitor mon_u (.sys_clk_i, .rst_i, .dmem_rd_o, .dmem_we_o, .busy_o,
	.flags_we_o, .qphase_o, .pc_o);

/* btox_dmem_model.sv */
// Data memory model behind the executor
module btox_dmem_model (input wire c_i, we_i, input wire [11:0] a_i, input wire [7:0] d_i,
	output wire [7:0] q_o);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] m [0:4095];
	assign q_o = m[a_i];
	always @(posedge c_i) if (we_i) m[a_i] <= d_i;
endmodule

/* tb.sv */
// Bench for the toggle and branch executor
`define CK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[ERR] %0t mismatch", $time); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 0, rst_i = 1, instr_valid_i = 0, skip_taken_i = 0, ovf_flag_i = 0;
	logic dmem_rd_o, dmem_we_o, busy_o, flags_we_o;
	logic skip_two_word_i = 0;
	logic [15:0] instr_i = 0;
	logic [3:0] bank_pointer_reg_i = 0;
	logic [7:0] dmem_rdata_i, dmem_wdata_o;
	logic [11:0] dmem_addr_o, ea;
	logic [1:0] qphase_o;
	logic [20:0] pc_o, pc = 0;
	logic [16:0] lf = 17'h1181A, r;
	logic [19:0] qd[$];
	int n_mismatch = 0, tests_run = 0, k;
	btox_exec dut_u (.*);
	btox_dmem_model mdl_u (.c_i(sys_clk_i), .we_i(dmem_we_o), .a_i(dmem_addr_o),
		.d_i(dmem_wdata_o), .q_o(dmem_rdata_i));
	initial forever #2 sys_clk_i = ~sys_clk_i;
	function automatic [16:0] nx(input [16:0] s);
		nx = {s[15:0], s[16] ^ s[13]};
	endfunction
	task wrap_up;
		if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task go(input [15:0] w, input o, s, t);
		k = 0;
		do begin
			@(posedge sys_clk_i);
			#1 k++;
		end while ((qphase_o !== 2'h3 || busy_o !== 1'b0) && k < 99);
		if (k > 98) begin
			n_mismatch++;
			wrap_up;
		end
		@(posedge sys_clk_i);
		instr_i <= w;
		instr_valid_i <= 1'b1;
		ovf_flag_i <= o;
		skip_taken_i <= s;
		skip_two_word_i <= t;
		bank_pointer_reg_i <= r[12:9];
		repeat (4) @(posedge sys_clk_i);
		instr_valid_i <= 1'b0;
		#1 `CK(pc_o, pc)
	endtask
	always @(posedge sys_clk_i) begin
		#1;
		if (dmem_we_o) begin
			`CK(qd.size() != 0, 1'b1)
			if (qd.size() != 0) `CK({dmem_addr_o, dmem_wdata_o}, qd.pop_front())
		end
	end
	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (40) begin
			repeat (17) lf = nx(lf);
			r = lf;
			repeat (17) lf = nx(lf);
			pc = pc + 21'h000002;
			ea = {lf[8] ? r[12:9] : 4'h0, lf[7:0]};
			if (lf[16]) begin
				if (lf[15]) pc = pc + {{12{lf[7]}}, lf[7:0], 1'b0};
				go({8'hE4, lf[7:0]}, lf[15], 1'b0, 1'b0);
			end else begin
				@(posedge sys_clk_i);
				#1 mdl_u.m[ea] = r[7:0];
				qd.push_back({ea, r[7:0] ^ (8'h01 << lf[11:9])});
				go({4'h7, lf[11:0]}, r[16], 1'b0, 1'b0);
			end
		end
		pc = pc + 21'h000002;
		go(16'hE400, 1'b0, 1'b1, 1'b0);
		`CK(busy_o, 1'b0)
		pc = pc + 21'h000002;
		go(16'hE400, 1'b0, 1'b1, 1'b1);
		repeat (7) @(posedge sys_clk_i);
		#1 `CK(busy_o, 1'b1)
		@(posedge sys_clk_i);
		#1 `CK(busy_o, 1'b0)
		`CK(pc_o, pc)
		`CK(qd.size(), 0)
		wrap_up;
	end
endmodule
